// ### adc_pkg.sv
// Purpose: shared constants for the converter serial retrieval block
// Assumes: 100 MHz ref_clk, 16-bit result and control words
// Notes:   field positions follow the control word layout
`default_nettype none
package adc_pkg;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned RAW_W         = 24;
  localparam int unsigned FIFO_DEPTH    = 4;
  localparam int unsigned CNT_W         = 5;
  localparam int unsigned TMO_W         = 22;

  // time constants
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCLK_TMO_MS   = 28;
  localparam int unsigned SCLK_TMO_CYC  = (SCLK_TMO_MS * 1000000) / CLK_PERIOD_NS;

  // reset values
  localparam logic [15:0] RESULT_RST    = 16'h0000;
  localparam logic [15:0] CTRL_RST      = 16'h058b;

  // full-scale codes
  localparam logic [15:0] POS_FS        = 16'h7fff;
  localparam logic [15:0] NEG_FS        = 16'h8000;
  localparam logic signed [RAW_W-1:0] RAW_POS_MAX = 24'sh007fff;
  localparam logic signed [RAW_W-1:0] RAW_NEG_MIN = 24'shff8000;

  // control word fields
  localparam int unsigned TRIG_BIT      = 15;
  localparam int unsigned PAIR_MSB      = 14;
  localparam int unsigned PAIR_LSB      = 12;
  localparam int unsigned GAIN_MSB      = 11;
  localparam int unsigned GAIN_LSB      = 9;
  localparam int unsigned MODE_BIT      = 8;
  localparam int unsigned RATE_MSB      = 7;
  localparam int unsigned RATE_LSB      = 5;
  localparam int unsigned TEMP_BIT      = 4;
  localparam int unsigned PULLUP_BIT    = 3;
  localparam int unsigned WV_MSB        = 2;
  localparam int unsigned WV_LSB        = 1;
  localparam int unsigned RSVD_BIT      = 0;
  localparam logic [1:0]  WRITE_VALID   = 2'h1;

  // bit counter marks
  localparam logic [3:0]  WORD_LAST     = 4'hf;
  localparam logic [CNT_W-1:0] FIRST_BIT = 5'h00;
  localparam logic [CNT_W-1:0] HALF_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] XFER_LAST = 5'h1f;

  // input pair selections
  typedef enum logic [2:0] {
    ADC_PAIR_01, ADC_PAIR_03, ADC_PAIR_13, ADC_PAIR_23,
    ADC_PAIR_0G, ADC_PAIR_1G, ADC_PAIR_2G, ADC_PAIR_3G
  } adc_pair_t;
endpackage : adc_pkg
`default_nettype wire

// ### adc_fifo.sv
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: single clock, async active-high reset
// Notes:   in_ready drops when full; out side may stall freely
`default_nettype none
module adc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             in_ready_r;
  logic             push;
  logic             pop;

  // full flag kept in a flop so the producer sees a registered ready
  assign in_ready  = in_ready_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      in_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr_r + 1'b1);
      end
      if (push && !pop) begin
        count_r    <= (AW+1)'(count_r + 1'b1);
        in_ready_r <= (count_r != (AW+1)'(DEPTH-1));
      end else if (pop && !push) begin
        count_r    <= (AW+1)'(count_r - 1'b1);
        in_ready_r <= 1'b1;
      end
    end
  end
endmodule // adc_fifo
`default_nettype wire

// ### adc_serial_data_retrieval.sv
// Purpose: serial result retrieval and control word path of a 16-bit converter
// Assumes: mode 1 link sampled by ref_clk; converter core outside
// Notes:   results queue in a 4-word FIFO ahead of the result buffer
`default_nettype none
module adc_serial_data_retrieval
  import adc_pkg::*;
#(
  parameter int unsigned SCLK_TIMEOUT_CYCLES = SCLK_TMO_CYC
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    cs_n,
  input  wire logic                    sclk,
  input  wire logic                    din,
  output logic                         data_out_ready_line,
  output logic                         data_out_ready_line_oe,
  output logic                         idle_output_pullup_enable,
  output logic [2:0]                   input_pair_select,
  output logic [2:0]                   gain_range_select,
  output logic [2:0]                   sample_rate_select,
  output logic                         single_shot_mode,
  output logic                         temperature_source_select,
  output logic [1:0]                   pos_input_index,
  output logic [1:0]                   neg_input_index,
  output logic                         neg_is_ground,
  output logic                         conv_start,
  input  wire logic                    conv_valid,
  input  wire logic signed [RAW_W-1:0] conv_raw,
  output logic                         conv_ready
);

  logic [2:0]        meta_r;
  logic [2:0]        sync_r;
  logic              sclk_dly_r;
  logic              cs_active;
  logic              sclk_s;
  logic              din_s;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              link_reset;
  logic              timeout_hit;
  logic [TMO_W-1:0]  tmo_cnt_r;
  logic [CNT_W-1:0]  rise_cnt_r;
  logic [CNT_W-1:0]  fall_cnt_r;
  logic              in_xfer_r;
  logic [15:0]       snap_r;
  logic [15:0]       echo_r;
  logic [15:0]       rx_r;
  logic [15:0]       rx_word;
  logic              word_done;
  logic [15:0]       ctrl_r;
  logic [15:0]       ctrl_nxt;
  logic              trig_req;
  logic [15:0]       result_r;
  logic              fresh_r;
  logic              dout_r;
  logic              dout_oe_r;
  logic              busy_r;
  logic              conv_start_r;
  logic              start_nxt;
  logic [15:0]       sat_code;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [15:0]       fifo_out_data;
  logic              result_load;
  logic [1:0]        pos_idx_r;
  logic [1:0]        neg_idx_r;
  logic              neg_gnd_r;

  // pin synchronisers: cs_n, sclk, din
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_r     <= 3'h7;
      sync_r     <= 3'h7;
      sclk_dly_r <= 1'b0;
    end else begin
      meta_r     <= {cs_n, sclk, din};
      sync_r     <= meta_r;
      sclk_dly_r <= sync_r[1];
    end
  end

  assign cs_active  = ~sync_r[2];
  assign sclk_s     = sync_r[1];
  assign din_s      = sync_r[0];
  assign sclk_rise  = cs_active & sclk_s & ~sclk_dly_r;
  assign sclk_fall  = cs_active & ~sclk_s & sclk_dly_r;
  assign link_reset = ~cs_active | timeout_hit;

  // clock held low too long restarts the bit counters
  assign timeout_hit = (tmo_cnt_r == TMO_W'(SCLK_TIMEOUT_CYCLES - 1));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tmo_cnt_r <= '0;
    end else if (!cs_active || sclk_s) begin
      tmo_cnt_r <= '0;
    end else if (tmo_cnt_r != TMO_W'(SCLK_TIMEOUT_CYCLES)) begin
      tmo_cnt_r <= TMO_W'(tmo_cnt_r + 1'b1);
    end
  end

  // bit counters wrap every 32 clocks for back-to-back transfers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rise_cnt_r <= '0;
      fall_cnt_r <= '0;
    end else if (link_reset) begin
      rise_cnt_r <= '0;
      fall_cnt_r <= '0;
    end else begin
      if (sclk_rise) begin
        rise_cnt_r <= CNT_W'(rise_cnt_r + 1'b1);
      end
      if (sclk_fall) begin
        fall_cnt_r <= CNT_W'(fall_cnt_r + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      in_xfer_r <= 1'b0;
    end else if (link_reset) begin
      in_xfer_r <= 1'b0;
    end else if (sclk_rise) begin
      in_xfer_r <= 1'b1;
    end else if (sclk_fall && fall_cnt_r == XFER_LAST) begin
      in_xfer_r <= 1'b0;
    end
  end

  // result locked at the first rising edge so it cannot change mid-read
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      snap_r <= RESULT_RST;
    end else if (sclk_rise && rise_cnt_r == FIRST_BIT) begin
      snap_r <= result_r;
    end
  end

  // output line: data during a transfer, ready flag otherwise
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dout_r    <= 1'b1;
      dout_oe_r <= 1'b0;
    end else begin
      dout_oe_r <= cs_active;
      if (!cs_active) begin
        dout_r <= 1'b1;
      end else if (sclk_rise) begin
        if (rise_cnt_r == FIRST_BIT) begin
          dout_r <= result_r[15];
        end else if (!rise_cnt_r[4]) begin
          dout_r <= snap_r[~rise_cnt_r[3:0]];
        end else begin
          dout_r <= echo_r[~rise_cnt_r[3:0]];
        end
      end else if (!in_xfer_r) begin
        dout_r <= ~fresh_r;
      end
    end
  end

  // control word receive, applied only on its sixteenth bit
  assign rx_word   = {rx_r[14:0], din_s};
  assign word_done = sclk_fall & (fall_cnt_r[3:0] == WORD_LAST);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_r <= '0;
    end else if (link_reset) begin
      rx_r <= '0;
    end else if (sclk_fall) begin
      rx_r <= rx_word;
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    trig_req = 1'b0;
    if (word_done && rx_word[WV_MSB:WV_LSB] == WRITE_VALID) begin
      ctrl_nxt           = rx_word;
      ctrl_nxt[TRIG_BIT] = 1'b0;
      ctrl_nxt[RSVD_BIT] = CTRL_RST[RSVD_BIT];
      trig_req           = rx_word[TRIG_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      echo_r <= CTRL_RST;
    end else if (word_done && fall_cnt_r == HALF_LAST) begin
      echo_r <= ctrl_nxt;
    end
  end

  // conversion sequencing
  always_comb begin
    start_nxt = 1'b0;
    if (!busy_r && !conv_start_r) begin
      if (!ctrl_r[MODE_BIT]) begin
        start_nxt = 1'b1;
      end else if (trig_req && ctrl_nxt[MODE_BIT]) begin
        start_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conv_start_r <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      conv_start_r <= start_nxt;
      if (start_nxt) begin
        busy_r <= 1'b1;
      end else if (conv_valid && conv_ready) begin
        busy_r <= 1'b0;
      end
    end
  end

  // clip converter values to the 16-bit code range
  always_comb begin
    if (conv_raw > RAW_POS_MAX) begin
      sat_code = POS_FS;
    end else if (conv_raw < RAW_NEG_MIN) begin
      sat_code = NEG_FS;
    end else begin
      sat_code = conv_raw[15:0];
    end
  end

  adc_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_result_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (conv_valid),
    .in_ready  (conv_ready),
    .in_data   (sat_code),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // buffer refresh stalls while a transfer is running
  assign fifo_out_ready = ~in_xfer_r & ~sclk_rise;
  assign result_load    = fifo_out_valid & fifo_out_ready;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      result_r <= RESULT_RST;
    end else if (result_load) begin
      result_r <= fifo_out_data;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fresh_r <= 1'b0;
    end else if (result_load) begin
      fresh_r <= 1'b1;
    end else if (sclk_rise && rise_cnt_r == FIRST_BIT) begin
      fresh_r <= 1'b0;
    end
  end

  // input pair decode
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pos_idx_r <= 2'h0;
      neg_idx_r <= 2'h1;
      neg_gnd_r <= 1'b0;
    end else begin
      neg_gnd_r <= ctrl_r[PAIR_MSB];
      case (adc_pair_t'(ctrl_r[PAIR_MSB:PAIR_LSB]))
        ADC_PAIR_01: begin
          pos_idx_r <= 2'h0;
          neg_idx_r <= 2'h1;
        end
        ADC_PAIR_03: begin
          pos_idx_r <= 2'h0;
          neg_idx_r <= 2'h3;
        end
        ADC_PAIR_13: begin
          pos_idx_r <= 2'h1;
          neg_idx_r <= 2'h3;
        end
        ADC_PAIR_23: begin
          pos_idx_r <= 2'h2;
          neg_idx_r <= 2'h3;
        end
        default: begin
          pos_idx_r <= ctrl_r[PAIR_LSB+1:PAIR_LSB];
          neg_idx_r <= 2'h0;
        end
      endcase
    end
  end

  assign data_out_ready_line       = dout_r;
  assign data_out_ready_line_oe    = dout_oe_r;
  assign idle_output_pullup_enable = ctrl_r[PULLUP_BIT];
  assign input_pair_select         = ctrl_r[PAIR_MSB:PAIR_LSB];
  assign gain_range_select         = ctrl_r[GAIN_MSB:GAIN_LSB];
  assign sample_rate_select        = ctrl_r[RATE_MSB:RATE_LSB];
  assign single_shot_mode          = ctrl_r[MODE_BIT];
  assign temperature_source_select = ctrl_r[TEMP_BIT];
  assign pos_input_index           = pos_idx_r;
  assign neg_input_index           = neg_idx_r;
  assign neg_is_ground             = neg_gnd_r;
  assign conv_start                = conv_start_r;

endmodule // adc_serial_data_retrieval
`default_nettype wire

// ### adc_sdr_properties.sv
// Purpose: concurrent checks on the retrieval block ports
// Assumes: single ref_clk domain, async active-high reset
// Notes:   bound into every instance of the block
`default_nettype none
module adc_sdr_properties
  import adc_pkg::*;
#(
  parameter int unsigned SCLK_TIMEOUT_CYCLES = SCLK_TMO_CYC
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       cs_n,
  input wire logic       data_out_ready_line_oe,
  input wire logic       idle_output_pullup_enable,
  input wire logic [2:0] input_pair_select,
  input wire logic [2:0] gain_range_select,
  input wire logic [2:0] sample_rate_select,
  input wire logic       single_shot_mode,
  input wire logic       temperature_source_select,
  input wire logic [1:0] pos_input_index,
  input wire logic [1:0] neg_input_index,
  input wire logic       neg_is_ground,
  input wire logic       conv_start,
  input wire logic       conv_valid,
  input wire logic       conv_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0]  pair_r;
  logic [11:0] cfg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  assign cfg = {input_pair_select, gain_range_select, single_shot_mode, sample_rate_select,
                temperature_source_select, idle_output_pullup_enable};

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pair_r <= 3'h0;
    end else begin
      pair_r <= input_pair_select;
    end
  end

  a_oe_release: assert property ($rose(cs_n) |-> ##[1:5] !data_out_ready_line_oe)
    else $error("line driver kept on after deselect");
  a_oe_drive: assert property (!cs_n [*6] |-> data_out_ready_line_oe)
    else $error("line driver off while selected");
  a_start_pulse: assert property (conv_start |=> !conv_start [*2])
    else $error("start pulse too long");
  a_cont_restart: assert property ((!single_shot_mode && conv_valid && conv_ready)
    |-> ##[1:8] (conv_start || single_shot_mode))
    else $error("continuous mode did not restart");
  a_gnd_decode: assert property (neg_is_ground == pair_r[2])
    else $error("ground decode wrong");
  a_pos_decode: assert property (pos_input_index ==
    (pair_r[2] ? pair_r[1:0] : ((pair_r[1:0] == 2'h0) ? 2'h0 : pair_r[1:0] - 2'h1)))
    else $error("positive input decode wrong");
  a_neg_decode: assert property (neg_input_index ==
    (pair_r[2] ? 2'h0 : ((pair_r[1:0] == 2'h0) ? 2'h1 : 2'h3)))
    else $error("negative input decode wrong");
  a_cfg_hold: assert property (cs_n [*6] |-> $stable(cfg))
    else $error("control changed while deselected");
  a_trig_link: assert property ((conv_start && single_shot_mode) |-> !$past(cs_n, 5))
    else $error("single shot start without a write");
endmodule // adc_sdr_properties

bind adc_serial_data_retrieval adc_sdr_properties #(
  .SCLK_TIMEOUT_CYCLES(SCLK_TIMEOUT_CYCLES)
) u_props (
  .ref_clk(ref_clk), .reset(reset), .cs_n(cs_n),
  .data_out_ready_line_oe(data_out_ready_line_oe),
  .idle_output_pullup_enable(idle_output_pullup_enable),
  .input_pair_select(input_pair_select), .gain_range_select(gain_range_select),
  .sample_rate_select(sample_rate_select), .single_shot_mode(single_shot_mode),
  .temperature_source_select(temperature_source_select),
  .pos_input_index(pos_input_index), .neg_input_index(neg_input_index),
  .neg_is_ground(neg_is_ground), .conv_start(conv_start),
  .conv_valid(conv_valid), .conv_ready(conv_ready)
);
`default_nettype wire

// ### adc_host_model.sv
// Purpose: mode 1 serial host running 8, 16 or 32 clock transfers
// Assumes: 160 ns link clock period, chip select actively driven
// Notes:   optional stall with the clock low after the eighth bit
`default_nettype none
module adc_host_model (
  output var logic cs_n,
  output var logic sclk,
  output var logic din,
  input  wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  task automatic xfer(input logic [31:0] tx, input int n, input int stall,
                      output logic [31:0] rx, output logic rdy);
    rx = 32'h0;
    cs_n = 1'b0;
    #400 rdy = line;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      din = tx[31-i];
      #80 sclk = 1'b0;
      rx = {rx[30:0], line};
      #80;
      if (i == 7) #(stall);
    end
    #100 cs_n = 1'b1;
    #300;
  endtask
endmodule // adc_host_model
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for the retrieval block
// Assumes: 100 MHz ref_clk, converter stub answers 20 cycles after start
// Notes:   line pulls high or toggles when the block releases it
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk, reset, cs_n, sclk, din, dout, oe, pu, mode, temp, conv_start, conv_ready, gnd;
  logic tog = 1'b0;
  logic acc = 1'b0;
  logic saw_full = 1'b0;
  logic conv_valid = 1'b0;
  logic signed [23:0] conv_raw = 24'sh0;
  logic [2:0]  pair, gain, rate;
  logic [1:0]  pos, neg;
  logic [11:0] cfg;
  logic [31:0] rx;
  logic        rdy;
  wire logic   line_w;
  int failures = 0;
  int n_checks = 0;
  int n_starts = 0;
  int busy = 0;

  assign cfg = {pair, gain, mode, rate, temp, pu};
  assign line_w = oe ? dout : (pu ? 1'b1 : tog);

  adc_host_model u_host (.cs_n(cs_n), .sclk(sclk), .din(din), .line(line_w));

  adc_serial_data_retrieval #(.SCLK_TIMEOUT_CYCLES(2000)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din),
    .data_out_ready_line(dout), .data_out_ready_line_oe(oe),
    .idle_output_pullup_enable(pu), .input_pair_select(pair), .gain_range_select(gain),
    .sample_rate_select(rate), .single_shot_mode(mode), .temperature_source_select(temp),
    .pos_input_index(pos), .neg_input_index(neg), .neg_is_ground(gnd),
    .conv_start(conv_start), .conv_valid(conv_valid), .conv_raw(conv_raw),
    .conv_ready(conv_ready)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // converter stub: one result 20 cycles after each start
  always @(posedge ref_clk) tog <= ~tog;
  always @(posedge ref_clk) acc <= conv_valid && conv_ready;
  always @(negedge ref_clk) begin
    if (acc) conv_valid <= 1'b0;
    if (conv_ready === 1'b0) saw_full = 1'b1;
    if (conv_start === 1'b1) begin
      n_starts++;
      busy = 20;
    end else if (busy == 1) begin
      busy = 0;
      conv_valid <= 1'b1;
    end else if (busy > 1) begin
      busy--;
    end
  end

  function automatic logic [11:0] fld(input logic [15:0] w);
    return w[14:3];
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic t_reset_state();
    chk("config", fld(16'h058b), cfg);
    u_host.xfer(32'hffffffff, 32, 0, rx, rdy);
    chk("ready", 1, rdy);
    chk("result", 16'h0000, rx[31:16]);
    chk("echo", 16'h058b, rx[15:0]);
    chk("config", fld(16'h058b), cfg);
  endtask

  task automatic t_refused();
    logic [15:0] w;
    for (int c = 0; c < 4; c++) begin
      if (c == 1) continue;
      w = {13'h0ade, c[1:0], 1'b1};
      u_host.xfer({w, w}, 32, 0, rx, rdy);
      chk("echo", 16'h058b, rx[15:0]);
      chk("config", fld(16'h058b), cfg);
    end
    u_host.xfer({16'h56f3, 16'h0}, 8, 0, rx, rdy);
    chk("config", fld(16'h058b), cfg);
  endtask

  task automatic t_pair_decode();
    logic [1:0] pe [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0] ne [4] = '{2'h1, 2'h3, 2'h3, 2'h3};
    logic [2:0] p;
    for (int k = 0; k < 8; k++) begin
      p = k[2:0];
      u_host.xfer({1'b0, p, 12'h58b, 16'h0}, 16, 0, rx, rdy);
      chk("pos_index", pe[k], pos);
      chk("ground", p[2], gnd);
      if (!p[2]) begin
        chk("neg_index", ne[p[1:0]], neg);
      end
    end
  endtask

  task automatic t_single_shot();
    logic signed [23:0] raws [4] = '{24'sh123456, 24'shfe0000, 24'shffffff, 24'sh000001};
    logic [15:0] exps [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0001};
    logic [15:0] prev;
    int s;
    prev = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk) conv_raw <= raws[i];
      s = n_starts;
      u_host.xfer({16'hd7f3, 16'h0}, 16, 0, rx, rdy);
      chk("result", prev, rx[15:0]);
      chk("ready", (i == 0), rdy);
      #600;
      chk("starts", s + 1, n_starts);
      prev = exps[i];
    end
    chk("config", fld(16'hd7f3), cfg);
    chk("decode", 3'h3, {pos, gnd});
    u_host.xfer(32'hffffffff, 16, 0, rx, rdy);
    chk("result", prev, rx[15:0]);
    chk("ready", 0, rdy);
    u_host.xfer(32'hffffffff, 16, 0, rx, rdy);
    chk("result", prev, rx[15:0]);
    chk("ready", 1, rdy);
  endtask

  task automatic t_continuous();
    int s;
    @(negedge ref_clk) conv_raw <= 24'sh000123;
    u_host.xfer({16'h56f3, 16'h56f3}, 32, 0, rx, rdy);
    chk("result", 16'h0001, rx[31:16]);
    chk("echo", 16'h56f3, rx[15:0]);
    s = n_starts;
    #2000;
    chk("restarts", 1, (n_starts - s) >= 4);
    saw_full = 1'b0;
    u_host.xfer(32'hffffffff, 32, 3000, rx, rdy);
    chk("result", 16'h0123, rx[31:16]);
    chk("fifo_full", 1, saw_full);
    u_host.xfer({16'h058b, 16'h0}, 16, 0, rx, rdy);
    #600;
    chk("mode", 1, mode);
    s = n_starts;
    #1000;
    chk("starts", s, n_starts);
    // clock held low past the limit: the remaining clocks begin a new frame
    u_host.xfer(32'hffffffff, 32, 21000, rx, rdy);
    chk("timeout", 16'h0123, rx[23:8]);
  endtask

  initial begin
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    #100;
    t_reset_state();
    t_refused();
    t_pair_decode();
    t_single_shot();
    t_continuous();
    complete_run();
  end

  initial begin
    #400us;
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    complete_run();
  end
endmodule // tb
`default_nettype wire
